// ### verilog/flash_status_write_protect.sv
// Purpose: Status registers and write protection of a serial flash
// Assumes: Link logic on sclk; array engine on clock reports completion by arrayDone
// Notes: Non-volatile bits are loaded from nvInit after reset release
`timescale 1ns/1ns
`include "flash_protect_cfg.svh"

// What this block does
// - Low status byte: guard0, block-protect 4..0, write-enable latch, busy flag.
// - High status byte: erase-paused, complement, locks 3..1, program-paused, quad, guard1.
// - Busy flag is high during program, erase or status write, else low.
// - Write-enable latch shown in status; clear latch refuses writes, programs, erases.
// - Block-protect bits change by status write only outside hardware protection.
// - Program and erases into the protected region are rejected; reads stay allowed.
// - Whole-array erase only for protect 000 with complement 0, or 111 with 1.
// - Complement set: code 000 protects everything, code 111 protects nothing.
// - Complement set, 00: codes 1..6 protect lower 63/64 down to 1/2.
// - Complement set, 01: codes 1..6 protect upper 63/64 down to 1/2.
// - Complement set, 10: protect all but top 4, 8, 16, 32 KB.
// - Complement set, 11: protect all but bottom 4, 8, 16, 32 KB.
// - Guards 00: status write accepted whenever latch set, pin ignored.
// - Guards 01: low protect pin locks status; high pin allows after latch set.
// - Guards 10: status writes blocked; power cycle returns guards to 00.
// - Guards 11: status writes refused for good.
// - Quad bit 0 keeps protect and pause pin roles; 1 makes them data lines.
// - Lock bits start 0, set individually by status write, never clear.
// - Complement bit non-volatile, default 0, inverts the protected range.
// - Suspend sets erase-paused or program-paused according to the suspended operation.
// - Resume, software reset pair and power cycle clear both paused flags.
// - Complement clear: 000 none, 111 all, others upper, lower, top, bottom.
// - Latch clears on power-up, reset, disable, status write, program, erases.
// - Hardware protection also guards block-protect and guard bits from change.
module flash_status_write_protect #(
    parameter int SR_WRITE_CYCLES = `SR_WRITE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sclk,
    input wire logic csN,
    input wire logic si,
    input wire logic wpN,
    input wire logic [15:0] nvInit,
    input wire logic arrayDone,
    output logic soData,
    output logic soOe,
    output flash_protect_pkg::status_low_t statusLow,
    output flash_protect_pkg::status_high_t statusHigh,
    output logic arrayStart,
    output flash_protect_pkg::array_kind_t arrayKind,
    output logic [21:0] arrayAddr,
    output logic suspendReq,
    output logic resumeReq
);

    // Link side, clocked by sclk
    wire frameRst_n = rst_n & ~csN;
    logic [2:0] bitCnt;
    logic [2:0] byteIdx;
    logic [7:0] shiftReg;
    flash_protect_pkg::frame_t frame;
    logic frameTog;
    logic pubSync1, pubSync2, pubSeen;
    logic [15:0] linkStatus;
    wire [7:0] newByte = {shiftReg[6:0], si};

    always_ff @(posedge sclk or negedge frameRst_n) begin
        if (!frameRst_n) begin
            bitCnt <= 3'h0;
            byteIdx <= 3'h0;
        end else begin
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7 && byteIdx != 3'h7) begin
                byteIdx <= byteIdx + 3'h1;
            end
        end
    end

    // Frame capture survives the deselect so the core can read it afterwards
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shiftReg <= 8'h00;
            frame <= '0;
            frameTog <= 1'b0;
        end else begin
            shiftReg <= newByte;
            frame.aligned <= (bitCnt == 3'h7);
            if (bitCnt == 3'h7) begin
                case (byteIdx)
                    3'h0: begin
                        frame.opcode <= newByte;
                        frame.byteCount <= 3'h1;
                        frameTog <= ~frameTog;
                    end
                    3'h1: begin
                        frame.byte1 <= newByte;
                        frame.byteCount <= 3'h2;
                    end
                    3'h2: begin
                        frame.byte2 <= newByte;
                        frame.byteCount <= 3'h3;
                    end
                    3'h3: begin
                        frame.byte3 <= newByte;
                        frame.byteCount <= 3'h4;
                    end
                    default: frame.byteCount <= 3'h5;
                endcase
            end
        end
    end

    // Status snapshot arrives by toggle handshake; word is stable while in flight
    logic [15:0] pubWord;
    logic pubTog;
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            pubSync1 <= 1'b0;
            pubSync2 <= 1'b0;
            pubSeen <= 1'b0;
            linkStatus <= 16'h0000;
        end else begin
            pubSync1 <= pubTog;
            pubSync2 <= pubSync1;
            if (pubSync2 != pubSeen) begin
                pubSeen <= pubSync2;
                linkStatus <= pubWord;
            end
        end
    end

    // Status byte shifts out msb first on the falling edge, repeating
    wire readLow = frame.opcode == `OP_READ_STATUS_LOW;
    wire readHigh = frame.opcode == `OP_READ_STATUS_HIGH;
    wire [7:0] readByte = readHigh ? linkStatus[15:8] : linkStatus[7:0];
    always_ff @(negedge sclk or negedge frameRst_n) begin
        if (!frameRst_n) begin
            soData <= 1'b0;
            soOe <= 1'b0;
        end else begin
            soOe <= (byteIdx != 3'h0) && (readLow || readHigh);
            soData <= readByte[3'h7 - bitCnt];
        end
    end

    // Core side, clocked by clock
    logic csSync1, csSync2, csPrev, csPrev2;
    logic frmSync1, frmSync2, frameSeen;
    logic wpSync1, wpSync2;
    logic ackSync1, ackSync2;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            csSync1 <= 1'b1;
            csSync2 <= 1'b1;
            csPrev <= 1'b1;
            csPrev2 <= 1'b1;
            frmSync1 <= 1'b0;
            frmSync2 <= 1'b0;
            wpSync1 <= 1'b1;
            wpSync2 <= 1'b1;
            ackSync1 <= 1'b0;
            ackSync2 <= 1'b0;
        end else if (ce) begin
            csSync1 <= csN;
            csSync2 <= csSync1;
            csPrev <= csSync2;
            csPrev2 <= csPrev;
            frmSync1 <= frameTog;
            frmSync2 <= frmSync1;
            wpSync1 <= wpN;
            wpSync2 <= wpSync1;
            ackSync1 <= pubSeen;
            ackSync2 <= ackSync1;
        end
    end

    // Deselect seen one cycle late so a byte toggle that raced it is caught
    wire execNow = ce && csPrev && !csPrev2 && (frmSync2 != frameSeen) && frame.aligned;

    logic loadPending, resetArmed;
    logic guard0, guard1, complementProtect, quadEnable, writeEnableLatch, busyFlag;
    logic erasePaused, programPaused, pausedErase;
    logic [4:0] blockProtect;
    logic [2:0] otpLock;
    flash_protect_pkg::busy_state_t state;
    logic [15:0] srTimer;

    function automatic logic guardAllows(input logic [1:0] guard, input logic wpHigh);
        case (guard)
            `GUARD_SOFTWARE: guardAllows = 1'b1;
            `GUARD_HARDWARE: guardAllows = wpHigh;
            default: guardAllows = 1'b0;
        endcase
    endfunction

    function automatic logic rangeHit(input logic [4:0] bp, input logic cmp,
            input logic [21:0] tLo, input logic [21:0] tHi);
        logic [21:0] lo, hi, size;
        logic empty, full, swap;
        empty = (bp[2:0] == 3'h0);
        full = (bp[2:0] == 3'h7);
        if (!bp[4]) begin
            size = `UNIT_64K << (bp[2:0] - 3'h1);
        end else if (bp[2]) begin
            size = `SIZE_32K;
        end else begin
            size = `UNIT_4K << (bp[2:0] - 3'h1);
        end
        lo = bp[3] ? 22'h000000 : `ARRAY_TOP - size + 22'h000001;
        hi = bp[3] ? size - 22'h000001 : `ARRAY_TOP;
        if (cmp) begin
            swap = empty;
            empty = full;
            full = swap;
            if (lo == 22'h000000) begin
                lo = hi + 22'h000001;
                hi = `ARRAY_TOP;
            end else begin
                hi = lo - 22'h000001;
                lo = 22'h000000;
            end
        end
        rangeHit = full || (!empty && !(tHi < lo || tLo > hi));
    endfunction

    // Command decode
    wire [7:0] op = frame.opcode;
    wire [2:0] nBytes = frame.byteCount;
    wire [21:0] cmdAddr = {frame.byte1[5:0], frame.byte2, frame.byte3};
    logic isArrayCmd;
    flash_protect_pkg::array_kind_t kind;
    logic [21:0] span;
    always_comb begin
        isArrayCmd = 1'b1;
        kind = flash_protect_pkg::KIND_PAGE;
        span = `SIZE_PAGE;
        case (op)
            `OP_PAGE_PROGRAM: isArrayCmd = (nBytes == 3'h5);
            `OP_ERASE_4K: begin
                kind = flash_protect_pkg::KIND_4K;
                span = `SIZE_4K;
                isArrayCmd = (nBytes == 3'h4);
            end
            `OP_ERASE_32K: begin
                kind = flash_protect_pkg::KIND_32K;
                span = `SIZE_32K;
                isArrayCmd = (nBytes == 3'h4);
            end
            `OP_ERASE_64K: begin
                kind = flash_protect_pkg::KIND_64K;
                span = `UNIT_64K;
                isArrayCmd = (nBytes == 3'h4);
            end
            `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
                kind = flash_protect_pkg::KIND_CHIP;
                isArrayCmd = (nBytes == 3'h1);
            end
            default: isArrayCmd = 1'b0;
        endcase
    end

    wire [21:0] tLo = cmdAddr & ~(span - 22'h000001);
    wire [21:0] tHi = tLo | (span - 22'h000001);
    wire chipAllowed = (blockProtect[2:0] == 3'h0 && !complementProtect) ||
        (blockProtect[2:0] == 3'h7 && complementProtect);
    wire blocked = (kind == flash_protect_pkg::KIND_CHIP) ? !chipAllowed :
        rangeHit(blockProtect, complementProtect, tLo, tHi);
    // Quad mode turns the protect pin into a data line, so it stops gating
    wire wpHigh = wpSync2 || quadEnable;
    wire idleExec = execNow && state == flash_protect_pkg::ST_IDLE;
    wire srCmd = idleExec && op == `OP_STATUS_WRITE && nBytes >= 3'h2;
    wire srWriteOk = srCmd && writeEnableLatch &&
        guardAllows({guard1, guard0}, wpHigh);
    wire arrayCmd = idleExec && isArrayCmd;
    wire arrayOk = arrayCmd && writeEnableLatch && !blocked;
    wire suspendOk = execNow && op == `OP_SUSPEND && nBytes == 3'h1 &&
        state == flash_protect_pkg::ST_ARRAY;
    wire resumeOk = execNow && op == `OP_RESUME && nBytes == 3'h1 &&
        state == flash_protect_pkg::ST_PAUSED;
    wire resetOk = execNow && op == `OP_RESET && nBytes == 3'h1 && resetArmed;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frameSeen <= 1'b0;
            resetArmed <= 1'b0;
        end else if (ce && csPrev && !csPrev2 && frmSync2 != frameSeen) begin
            frameSeen <= frmSync2;
            resetArmed <= execNow && op == `OP_RESET_ENABLE && nBytes == 3'h1;
        end
    end

    // Write-enable latch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            writeEnableLatch <= 1'b0;
        end else if (ce) begin
            if (resetOk || (idleExec && op == `OP_WRITE_DISABLE) || srCmd || arrayCmd) begin
                writeEnableLatch <= 1'b0;
            end else if (idleExec && op == `OP_WRITE_ENABLE && nBytes == 3'h1) begin
                writeEnableLatch <= 1'b1;
            end
        end
    end

    wire [7:0] newLow = frame.byte1;
    wire [7:0] newHigh = frame.byte2;
    wire hasHigh = nBytes >= 3'h3;

    // Non-volatile bits: loaded once after reset, then only by accepted status writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loadPending <= 1'b1;
            guard0 <= 1'b0;
            guard1 <= 1'b0;
            blockProtect <= 5'h00;
            complementProtect <= 1'b0;
            quadEnable <= 1'b0;
            otpLock <= 3'h0;
        end else if (ce) begin
            if (loadPending) begin
                loadPending <= 1'b0;
                blockProtect <= nvInit[6:2];
                complementProtect <= nvInit[14];
                quadEnable <= nvInit[9];
                otpLock <= nvInit[13:11];
                // Power lock-down does not survive a power cycle
                if ({nvInit[8], nvInit[7]} != `GUARD_POWER_LOCK) begin
                    guard1 <= nvInit[8];
                    guard0 <= nvInit[7];
                end
            end else if (srWriteOk) begin
                guard0 <= newLow[7];
                blockProtect <= newLow[6:2];
                if (hasHigh) begin
                    complementProtect <= newHigh[14 - 8];
                    otpLock <= otpLock | newHigh[13 - 8:11 - 8];
                    quadEnable <= newHigh[9 - 8];
                    guard1 <= newHigh[8 - 8];
                end
            end
        end
    end

    // Busy tracking, suspend and resume
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= flash_protect_pkg::ST_IDLE;
            busyFlag <= 1'b0;
            srTimer <= 16'h0000;
            erasePaused <= 1'b0;
            programPaused <= 1'b0;
            pausedErase <= 1'b0;
            arrayStart <= 1'b0;
            arrayKind <= flash_protect_pkg::KIND_PAGE;
            arrayAddr <= 22'h000000;
            suspendReq <= 1'b0;
            resumeReq <= 1'b0;
        end else if (ce) begin
            arrayStart <= 1'b0;
            suspendReq <= 1'b0;
            resumeReq <= 1'b0;
            if (resetOk) begin
                erasePaused <= 1'b0;
                programPaused <= 1'b0;
            end
            case (state)
                flash_protect_pkg::ST_IDLE: begin
                    if (srWriteOk) begin
                        state <= flash_protect_pkg::ST_STATUS_WRITE;
                        busyFlag <= 1'b1;
                        srTimer <= 16'(SR_WRITE_CYCLES);
                    end else if (arrayOk) begin
                        state <= flash_protect_pkg::ST_ARRAY;
                        busyFlag <= 1'b1;
                        arrayStart <= 1'b1;
                        arrayKind <= kind;
                        arrayAddr <= tLo;
                        pausedErase <= (kind != flash_protect_pkg::KIND_PAGE);
                    end
                end
                flash_protect_pkg::ST_STATUS_WRITE: begin
                    srTimer <= srTimer - 16'h0001;
                    if (srTimer == 16'h0001) begin
                        state <= flash_protect_pkg::ST_IDLE;
                        busyFlag <= 1'b0;
                    end
                end
                flash_protect_pkg::ST_ARRAY: begin
                    if (arrayDone) begin
                        state <= flash_protect_pkg::ST_IDLE;
                        busyFlag <= 1'b0;
                    end else if (suspendOk) begin
                        state <= flash_protect_pkg::ST_PAUSED;
                        busyFlag <= 1'b0;
                        suspendReq <= 1'b1;
                        erasePaused <= pausedErase;
                        programPaused <= !pausedErase;
                    end
                end
                flash_protect_pkg::ST_PAUSED: begin
                    if (resetOk) begin
                        state <= flash_protect_pkg::ST_IDLE;
                    end else if (resumeOk) begin
                        state <= flash_protect_pkg::ST_ARRAY;
                        busyFlag <= 1'b1;
                        resumeReq <= 1'b1;
                        erasePaused <= 1'b0;
                        programPaused <= 1'b0;
                    end
                end
                default: state <= flash_protect_pkg::ST_IDLE;
            endcase
        end
    end

    // Volatile bits come only from internal state, never from written data
    assign statusLow = '{guard0, blockProtect, writeEnableLatch, busyFlag};
    assign statusHigh = '{erasePaused, complementProtect, otpLock, programPaused,
        quadEnable, guard1};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pubWord <= 16'h0000;
            pubTog <= 1'b0;
        end else if (ce && ackSync2 == pubTog && {statusHigh, statusLow} != pubWord) begin
            pubWord <= {statusHigh, statusLow};
            pubTog <= ~pubTog;
        end
    end

    a_busy_on_write: assert property (@(posedge clock) disable iff (!rst_n)
        srWriteOk |=> busyFlag [*2])
        else $error("busy flag not raised by status write");
    a_latch_gates_bp: assert property (@(posedge clock) disable iff (!rst_n)
        (!$past(loadPending) && $changed(blockProtect)) |-> $past(writeEnableLatch))
        else $error("protect bits changed without write enable");
    a_hw_lock_bp: assert property (@(posedge clock) disable iff (!rst_n)
        (!loadPending && {guard1, guard0} == `GUARD_HARDWARE && !wpSync2 && !quadEnable)
        |=> $stable(blockProtect) && $stable(guard0))
        else $error("hardware protection let protect bits change");
    a_lock_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        !$past(loadPending) |-> ($past(otpLock) & ~otpLock) == 3'h0)
        else $error("lock bit cleared");
    a_chip_gate: assert property (@(posedge clock) disable iff (!rst_n)
        (arrayStart && arrayKind == flash_protect_pkg::KIND_CHIP) |->
        $past(chipAllowed))
        else $error("whole-array erase started while protected");
    a_reject_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        (arrayCmd && blocked) |=> !arrayStart && !busyFlag)
        else $error("protected command started array operation");
    a_wel_cleared: assert property (@(posedge clock) disable iff (!rst_n)
        (srCmd || arrayCmd) |=> !writeEnableLatch)
        else $error("write enable latch not cleared");
    a_suspend_flag: assert property (@(posedge clock) disable iff (!rst_n)
        (suspendOk && !arrayDone) |=> (erasePaused != programPaused) && !busyFlag)
        else $error("suspend flag wrong");
    a_resume_clear: assert property (@(posedge clock) disable iff (!rst_n)
        resumeOk |=> !erasePaused && !programPaused && busyFlag)
        else $error("resume left paused flag set");
    a_guard_block: assert property (@(posedge clock) disable iff (!rst_n)
        (srCmd && guard1) |=> state != flash_protect_pkg::ST_STATUS_WRITE)
        else $error("status write accepted under lock-down");

endmodule

// ### verilog/flash_protect_cfg.svh
// Purpose: Constants for the flash status and write-protect block
// Assumes: 4 MB array, 22-bit byte address, opcodes as seen on the serial link
// Notes: Definitions only
`ifndef FLASH_PROTECT_CFG_SVH
`define FLASH_PROTECT_CFG_SVH

`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS_LOW 8'h05
`define OP_READ_STATUS_HIGH 8'h35
`define OP_STATUS_WRITE 8'h01
`define OP_PAGE_PROGRAM 8'h02
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hd8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hc7
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99

`define ARRAY_TOP 22'h3fffff
`define UNIT_64K 22'h010000
`define UNIT_4K 22'h001000
`define SIZE_32K 22'h008000
`define SIZE_PAGE 22'h000100
`define SIZE_4K 22'h001000

`define GUARD_SOFTWARE 2'h0
`define GUARD_HARDWARE 2'h1
`define GUARD_POWER_LOCK 2'h2
`define GUARD_ONE_TIME 2'h3

`define SR_WRITE_CYCLES 16

`endif

// ### verilog/flash_protect_pkg.sv
// Purpose: Types for the flash status and write-protect block
// Assumes: Bit order follows the two status bytes, msb first
// Notes: Constants live in flash_protect_cfg.svh
package flash_protect_pkg;

    typedef struct packed {
        logic guard0;
        logic [4:0] blockProtect;
        logic writeEnableLatch;
        logic busyFlag;
    } status_low_t;

    typedef struct packed {
        logic erasePaused;
        logic complementProtect;
        logic [2:0] otpLock;
        logic programPaused;
        logic quadEnable;
        logic guard1;
    } status_high_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [7:0] byte3;
        logic [2:0] byteCount;
        logic aligned;
    } frame_t;

    typedef enum logic [2:0] {
        KIND_PAGE = 3'b000,
        KIND_4K = 3'b001,
        KIND_32K = 3'b010,
        KIND_64K = 3'b011,
        KIND_CHIP = 3'b100
    } array_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STATUS_WRITE = 2'b01,
        ST_ARRAY = 2'b10,
        ST_PAUSED = 2'b11
    } busy_state_t;

endpackage

// ### tb/flash_host_model.sv
// Purpose: Host serial controller model on the flash link
// Assumes: Mode 0; link clock stands low outside frames
// Notes: Data line shows inverse of its last bit when idle
`timescale 1ns/1ns
module flash_host_model (
    output logic sclk,
    output logic csN,
    output logic si,
    input wire logic soData
);
    logic [7:0] rx;
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        si = 1'b0;
    end
    // Frames never set the quad bit, so tied pins stay safe
    // Offsets keep link edges clear of core clock edges; a call lasts whole core periods
    task automatic xfer(input logic [39:0] d, input int n);
        #3 csN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = d[i];
            #15 sclk = 1'b1;
            if (i < 8) rx[i] = soData;
            #15 sclk = 1'b0;
        end
        #15 csN = 1'b1;
        si = ~si;
        // Gap covers execution and the minimum deselect time
        #142;
    endtask
endmodule

// ### tb/test_flash_status_write_protect.sv
// Purpose: Self-checking bench for the status and write-protect block
// Assumes: Status write busy time shortened to 4 cycles
// Notes: Frames come from the host model on a 30 ns link clock
`timescale 1ns/1ns
module test_flash_status_write_protect;
    logic clock, rst_n, wpN, arrayDone, sclk, csN, si, soData, soOe;
    logic arrayStart, suspendReq, resumeReq;
    logic [21:0] arrayAddr;
    flash_protect_pkg::status_low_t statusLow;
    flash_protect_pkg::status_high_t statusHigh;
    flash_protect_pkg::array_kind_t arrayKind;
    int failures = 0, compares = 0, starts = 0, busyCnt = 0;
    int reads = 0, pauses = 0, resumes = 0;
    logic [15:0] nvImage = 16'h0000;
    flash_status_write_protect #(.SR_WRITE_CYCLES(4)) dut (
        .clock(clock), .rst_n(rst_n), .ce(1'b1), .sclk(sclk), .csN(csN),
        .si(si), .wpN(wpN), .nvInit(nvImage), .arrayDone(arrayDone),
        .soData(soData), .soOe(soOe), .statusLow(statusLow),
        .statusHigh(statusHigh), .arrayStart(arrayStart), .arrayKind(arrayKind),
        .arrayAddr(arrayAddr), .suspendReq(suspendReq), .resumeReq(resumeReq));
    flash_host_model h (.sclk(sclk), .csN(csN), .si(si), .soData(soData));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (arrayStart === 1'b1) starts <= starts + 1;
        if (statusLow.busyFlag === 1'b1) busyCnt <= busyCnt + 1;
        if (suspendReq === 1'b1) pauses <= pauses + 1;
        if (resumeReq === 1'b1) resumes <= resumes + 1;
    end
    always @(posedge soOe) reads++;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        wpN = 1'b1;
        arrayDone = 1'b0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        check("low", statusLow, 8'h00);
        h.xfer(32'h06, 8);
        check("low", statusLow, 8'h02);
        h.xfer(32'h010440, 24);
        check("busy", busyCnt, 4);
        check("low", statusLow, 8'h04);
        check("high", statusHigh, 8'h40);
        h.xfer(32'h0500, 16);
        check("read", h.rx, 8'h04);
        h.xfer(32'h3500, 16);
        check("read", h.rx, 8'h40);
        check("reads", reads, 2);
        h.xfer(32'h06, 8);
        h.xfer(32'h203f0000, 32);
        check("starts", starts, 1);
        check("kind", arrayKind, flash_protect_pkg::KIND_4K);
        check("addr", arrayAddr, 22'h3f0000);
        check("low", statusLow, 8'h05);
        h.xfer(32'h75, 8);
        check("high", statusHigh, 8'hc0);
        h.xfer(32'h7a, 8);
        check("high", statusHigh, 8'h40);
        @(negedge clock) arrayDone = 1'b1;
        @(negedge clock) arrayDone = 1'b0;
        @(negedge clock);
        check("low", statusLow, 8'h04);
        h.xfer(32'h06, 8);
        h.xfer(32'h20000000, 32);
        check("low", statusLow, 8'h04);
        h.xfer(32'h06, 8);
        h.xfer(32'h60, 8);
        h.xfer(32'h203f0000, 32);
        check("starts", starts, 1);
        h.xfer(32'h06, 8);
        h.xfer(32'h0184, 16);
        check("low", statusLow, 8'h84);
        @(negedge clock) wpN = 1'b0;
        h.xfer(32'h06, 8);
        h.xfer(32'h0100, 16);
        check("low", statusLow, 8'h84);
        @(negedge clock) wpN = 1'b1;
        h.xfer(32'h06, 8);
        h.xfer(32'h010000, 24);
        check("low", statusLow, 8'h00);
        check("high", statusHigh, 8'h00);
        h.xfer(32'h06, 8);
        check("low", statusLow, 8'h02);
        h.xfer(32'h04, 8);
        check("low", statusLow, 8'h00);
        h.xfer(32'h06, 8);
        h.xfer(32'h60, 8);
        check("kind", arrayKind, flash_protect_pkg::KIND_CHIP);
        check("starts", starts, 2);
        @(negedge clock) arrayDone = 1'b1;
        @(negedge clock) arrayDone = 1'b0;
        h.xfer(32'h06, 8);
        h.xfer(40'h02001234aa, 40);
        check("kind", arrayKind, flash_protect_pkg::KIND_PAGE);
        check("addr", arrayAddr, 22'h001200);
        h.xfer(32'h75, 8);
        check("high", statusHigh, 8'h04);
        h.xfer(32'h66, 8);
        h.xfer(32'h99, 8);
        check("high", statusHigh, 8'h00);
        check("low", statusLow, 8'h00);
        check("pauses", pauses, 2);
        check("resumes", resumes, 1);
        h.xfer(32'h06, 8);
        h.xfer(32'h010001, 24);
        check("high", statusHigh, 8'h01);
        h.xfer(32'h06, 8);
        h.xfer(32'h010400, 24);
        check("low", statusLow, 8'h00);
        @(negedge clock) rst_n = 1'b0;
        nvImage = 16'h5944;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        check("low", statusLow, 8'h44);
        check("high", statusHigh, 8'h58);
        h.xfer(32'h06, 8);
        h.xfer(32'h203fe000, 32);
        check("starts", starts, 3);
        h.xfer(32'h06, 8);
        h.xfer(32'h203ff000, 32);
        check("starts", starts, 4);
        check("addr", arrayAddr, 22'h3ff000);
        @(negedge clock) arrayDone = 1'b1;
        @(negedge clock) arrayDone = 1'b0;
        h.xfer(32'h06, 8);
        h.xfer(32'h014440, 24);
        check("high", statusHigh, 8'h58);
        conclude();
    end
endmodule
